/* rcad_pkg.sv */
// ****************************************************************
// Constants and types of the RC-oscillation converter counters
// ****************************************************************
package rcad_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFFS_MODE   = 5'h00;
  localparam logic [ADDR_W-1:0] OFFS_CTRL   = 5'h04;
  localparam logic [ADDR_W-1:0] OFFS_A_LOW  = 5'h08;
  localparam logic [ADDR_W-1:0] OFFS_A_HIGH = 5'h0c;
  localparam logic [ADDR_W-1:0] OFFS_B_LOW  = 5'h10;
  localparam logic [ADDR_W-1:0] OFFS_B_HIGH = 5'h14;
  // Distance between the low words of counter A and counter B
  localparam logic [ADDR_W-1:0] OFFS_CNT_STEP = 5'h08;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int CNT_W        = 24;
  localparam int LOW_W        = 16;
  localparam int HIGH_W       = CNT_W - LOW_W;
  localparam int MODE_W       = 5;
  localparam int OSC_MODE_W   = 4;
  localparam int REF_SEL_BIT  = 4;
  localparam int OFF_MODE_BIT = 3;
  localparam int RUN_BIT      = 0;
  localparam int CNT_A        = 0;
  localparam int CNT_B        = 1;
  localparam int NUM_CNT      = 2;
  localparam logic [MODE_W-1:0] MODE_RESET = 5'h00;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 24'h000000;
  localparam logic [CNT_W-1:0]  CNT_ALL1   = 24'hffffff;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h00000000;

  // ****************************************************************
  // Conversion sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    RCAD_IDLE  = 2'b00,
    RCAD_ARM   = 2'b01,
    RCAD_COUNT = 2'b10
  } rcad_state_type;

  // Avalon-MM request from the master
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } rcad_avm_req_type;

endpackage

/* rcad_rc_net.sv */
`timescale 1ns/1ps
// ****************
// RC network: oscillates only while enabled
// ****************
module rcad_rc_net
#(parameter int HALF = 3)
(
  // System
  input wire logic  clk,
  input wire logic  nrst,
  // Control and clock
  input wire logic  osc_enable,
  output logic      oscillator_clock
);
  int cnt;
  // Pin rests low between conversions
  always_ff @(posedge clk)
  begin
    if (!nrst || !osc_enable)
    begin
      cnt <= 0;
      oscillator_clock <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      oscillator_clock <= ~oscillator_clock;
    end
    else
      cnt <= cnt + 1;
  end
endmodule // rcad_rc_net

/* rcad_top.sv */
`timescale 1ns/1ps
// ****************************************************************
// Behaviour
// RULE1: Mode 0: A gates on base clock, B counts
// RULE2: Mode 1: B gates on oscillator, A counts
// RULE3: 24-bit presettable counters; overflow ends gate
// RULE4: Software zeroes the result counter first
// RULE5: Mode 0: A counts once run and qualified
// RULE6: Mode 0: A overflow clears run, raises request
// RULE7: Mode 0: oscillator and B run while qualified
// RULE8: Mode 1: B overflow clears run, raises request
// RULE9: Mode 1: A counts base clocks while qualified
// RULE10: Writing 01H to control starts conversion
// RULE11: Mode register: field low four bits, mode 0
// RULE12: Reference select sits in mode bit four
// RULE13: Mode field top bit set: no oscillator
// RULE14: Mode 0: B holds oscillator clocks in gate
// RULE15: Software selects the slow base clock
// RULE16: Two conversions; software takes the ratio
// RULE17: Reference step in mode 1 recommended
// RULE18: Larger preset lowers quantisation error
// RULE19: Software halts until the request wakes it
// RULE20: Clock edges synchronised before any stop decision
// ****************************************************************
module rcad_top
(
  // System
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // Avalon-MM slave
  input  wire rcad_pkg::rcad_avm_req_type avs_req,
  output logic [rcad_pkg::DATA_W-1:0]   avs_readdata,
  output logic                          avs_waitrequest,
  // Clocks to be counted
  input  wire logic                     base_clock,
  input  wire logic                     oscillator_clock,
  // Oscillator control
  output logic                          osc_enable,
  output logic [rcad_pkg::OSC_MODE_W-1:0] oscillation_mode_field,
  // Event
  output logic                          conv_interrupt_request
);
  import rcad_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [BE_W-1:0]   be
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int k = 0; k < BE_W; k++)
    begin
      if (be[k])
        res[k*8 +: 8] = new_val[k*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offs
  );
    return addr == offs;
  endfunction

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // One wait cycle on every access keeps read data in a flop.
  logic bus_ack;
  wire  bus_req  = avs_req.read | avs_req.write;
  wire  bus_take = bus_req & bus_ack;
  wire  wr_take  = bus_take & avs_req.write;

  assign avs_waitrequest = bus_req & ~bus_ack;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      bus_ack <= 1'b0;
    else
      bus_ack <= bus_req & ~bus_ack;
  end

  // ****************************************************************
  // Clock edge detection
  // ****************************************************************
  // Both counted clocks are slow against clk; they pass two flops
  // before any edge is looked at, so a stop never sees a half level.
  logic [2:0] base_sync;
  logic [2:0] osc_sync;
  wire  base_rise = base_sync[1] & ~base_sync[2];
  wire  base_fall = ~base_sync[1] & base_sync[2];
  wire  osc_rise  = osc_sync[1] & ~osc_sync[2];

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      base_sync <= 3'h0;
      osc_sync  <= 3'h0;
    end
    else
    begin
      base_sync <= {base_sync[1:0], base_clock};       // [RULE20]
      osc_sync  <= {osc_sync[1:0], oscillator_clock};  // [RULE20]
    end
  end

  // ****************************************************************
  // Mode register
  // ****************************************************************
  logic [MODE_W-1:0] mode;
  wire  ref_sel = mode[REF_SEL_BIT];                   // [RULE12]
  wire  wr_mode = wr_take & hit(avs_req.address, OFFS_MODE);
  wire  wr_ctrl = wr_take & hit(avs_req.address, OFFS_CTRL);
  wire  run_req = avs_req.writedata[RUN_BIT];

  always_ff @(posedge clk)
  begin
    if (!nrst)
      mode <= MODE_RESET;
    else if (wr_mode && avs_req.byteenable[0])
      mode <= avs_req.writedata[MODE_W-1:0];           // [RULE11] [RULE12]
  end

  assign oscillation_mode_field = mode[OSC_MODE_W-1:0]; // [RULE11]

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  rcad_state_type state;
  rcad_state_type next_state;
  logic [NUM_CNT-1:0] cnt_ovf;

  wire counting = state == RCAD_COUNT;
  wire run_bit  = state != RCAD_IDLE;
  // Gating counter: A in mode 0, B in mode 1
  wire gate_ovf = counting & (ref_sel ? cnt_ovf[CNT_B] : cnt_ovf[CNT_A]); // [RULE6] [RULE8]

  always_comb
  begin
    next_state = state;
    case (state)
      RCAD_IDLE:
      begin
        if (wr_ctrl && run_req)
          next_state = RCAD_ARM;                       // [RULE10]
      end
      RCAD_ARM:
      begin
        if (wr_ctrl && !run_req)
          next_state = RCAD_IDLE;
        else if (base_fall)
          next_state = RCAD_COUNT;                     // [RULE5]
      end
      RCAD_COUNT:
      begin
        if (wr_ctrl && !run_req)
          next_state = RCAD_IDLE;
        else if (gate_ovf)
          next_state = RCAD_IDLE;                      // [RULE6] [RULE8]
      end
      default:
        next_state = RCAD_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state                  <= RCAD_IDLE;
      conv_interrupt_request <= 1'b0;
    end
    else
    begin
      state                  <= next_state;
      conv_interrupt_request <= gate_ovf;              // [RULE6] [RULE8]
    end
  end

  // Prohibited modes never release the oscillator
  assign osc_enable = counting & ~mode[OFF_MODE_BIT];  // [RULE7] [RULE13]

  // ****************************************************************
  // Counters A and B
  // ****************************************************************
  logic [CNT_W-1:0]   cnt [NUM_CNT];
  logic [NUM_CNT-1:0] cnt_inc;

  // A counts base clocks in both modes; B counts oscillator clocks
  assign cnt_inc[CNT_A] = counting & base_rise;        // [RULE1] [RULE5] [RULE9]
  assign cnt_inc[CNT_B] = osc_enable & osc_rise;       // [RULE2] [RULE7] [RULE14]

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++)
    begin : g_cnt
      localparam logic [ADDR_W-1:0] LO_OFFS =
        ADDR_W'(OFFS_A_LOW + gi * OFFS_CNT_STEP);
      localparam logic [ADDR_W-1:0] HI_OFFS =
        ADDR_W'(OFFS_A_HIGH + gi * OFFS_CNT_STEP);
      wire wr_lo = wr_take & hit(avs_req.address, LO_OFFS);
      wire wr_hi = wr_take & hit(avs_req.address, HI_OFFS);
      wire [DATA_W-1:0] lo_new = merge_bytes(
        {{(DATA_W-LOW_W){1'b0}}, cnt[gi][LOW_W-1:0]},
        avs_req.writedata, avs_req.byteenable);
      wire [DATA_W-1:0] hi_new = merge_bytes(
        {{(DATA_W-HIGH_W){1'b0}}, cnt[gi][CNT_W-1:LOW_W]},
        avs_req.writedata, avs_req.byteenable);

      // Wrap of the gating counter from all ones to zero ends the gate
      assign cnt_ovf[gi] = cnt_inc[gi] & (cnt[gi] == CNT_ALL1); // [RULE3]

      // A software preset takes precedence over a count in that cycle
      always_ff @(posedge clk)
      begin
        if (!nrst)
          cnt[gi] <= CNT_RESET;
        else if (wr_lo)
          cnt[gi][LOW_W-1:0] <= lo_new[LOW_W-1:0];     // [RULE3]
        else if (wr_hi)
          cnt[gi][CNT_W-1:LOW_W] <= hi_new[HIGH_W-1:0]; // [RULE3]
        else if (cnt_inc[gi])
          cnt[gi] <= cnt[gi] + 1'b1;                   // [RULE3]
      end
    end
  endgenerate

  // ****************************************************************
  // Read path
  // ****************************************************************
  wire [ADDR_W-1:0] rd_addr = avs_req.address;

  // Every register is shown right-aligned with reserved bits zero,
  // so software may compare whole words without masking.
  wire [DATA_W-1:0] rd_mode   = {{(DATA_W-MODE_W){1'b0}}, mode};
  wire [DATA_W-1:0] rd_ctrl   = {{(DATA_W-1){1'b0}}, run_bit};
  wire [DATA_W-1:0] rd_a_low  = {{(DATA_W-LOW_W){1'b0}}, cnt[CNT_A][LOW_W-1:0]};
  wire [DATA_W-1:0] rd_a_high = {{(DATA_W-HIGH_W){1'b0}}, cnt[CNT_A][CNT_W-1:LOW_W]};
  wire [DATA_W-1:0] rd_b_low  = {{(DATA_W-LOW_W){1'b0}}, cnt[CNT_B][LOW_W-1:0]};
  wire [DATA_W-1:0] rd_b_high = {{(DATA_W-HIGH_W){1'b0}}, cnt[CNT_B][CNT_W-1:LOW_W]};

  // Unmapped offsets read zero rather than aliasing a register
  logic [DATA_W-1:0] rd_mux;

  always_comb
  begin
    rd_mux = DATA_ZERO;
    case (rd_addr)
      OFFS_MODE:
        rd_mux = rd_mode;
      OFFS_CTRL:
        rd_mux = rd_ctrl;
      OFFS_A_LOW:
        rd_mux = rd_a_low;
      OFFS_A_HIGH:
        rd_mux = rd_a_high;
      OFFS_B_LOW:
        rd_mux = rd_b_low;
      OFFS_B_HIGH:
        rd_mux = rd_b_high;
      default:
        rd_mux = DATA_ZERO;
    endcase
  end

  // Counters are read in two halves; a count may fall between the
  // two reads, so software reads a result only after the request.

  always_ff @(posedge clk)
  begin
    if (!nrst)
      avs_readdata <= DATA_ZERO;
    else if (avs_req.read && !bus_ack)
      avs_readdata <= rd_mux;
  end

endmodule // rcad_top

/* rcad_top_properties.sv */
`timescale 1ns/1ps
// ****************
// Port checks
// ****************
module rcad_chk
  import rcad_pkg::*;
(
  // System
  input wire logic                    clk,
  input wire logic                    nrst,
  // Bus
  input wire rcad_avm_req_type        avs_req,
  input wire logic [DATA_W-1:0]       avs_readdata,
  input wire logic                    avs_waitrequest,
  // Oscillator and event
  input wire logic                    osc_enable,
  input wire logic [OSC_MODE_W-1:0]   oscillation_mode_field,
  input wire logic                    conv_interrupt_request
);
  wire req  = avs_req.read | avs_req.write;
  wire done = req & ~avs_waitrequest;
  wire barred = oscillation_mode_field[OFF_MODE_BIT];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_WAIT_ONE: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state too long");
  AST_NO_WAIT_IDLE: assert property (!req |-> !avs_waitrequest)
    else $error("wait without request");
  AST_IRQ_PULSE: assert property (conv_interrupt_request |=> !conv_interrupt_request)
    else $error("request longer than one cycle");
  AST_IRQ_STOPS_OSC: assert property (conv_interrupt_request |-> !osc_enable)
    else $error("oscillator still on at request");
  AST_IRQ_AFTER_RUN: assert property (conv_interrupt_request && !barred |->
    $past(osc_enable, 2) || $past(osc_enable, 3))
    else $error("request without a run");
  AST_OSC_BARRED: assert property (barred |-> !osc_enable)
    else $error("oscillator on in barred mode");
  AST_MODE_BY_WRITE: assert property (!$stable(oscillation_mode_field) |->
    $past(done && avs_req.write && avs_req.address == OFFS_MODE))
    else $error("mode field changed without write");
  AST_UNMAPPED_ZERO: assert property (done && avs_req.read && avs_req.address > 5'h17 |->
    avs_readdata == DATA_ZERO)
    else $error("unmapped read not zero");
  cover property (conv_interrupt_request);
  cover property ($rose(osc_enable));
  cover property (done && avs_req.read && avs_req.address == OFFS_CTRL);
endmodule // rcad_chk

bind rcad_top rcad_chk rcad_chk_inst (.clk(clk), .nrst(nrst), .avs_req(avs_req),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .osc_enable(osc_enable),
  .oscillation_mode_field(oscillation_mode_field),
  .conv_interrupt_request(conv_interrupt_request));

/* rcad_top_tb.sv */
`timescale 1ns/1ps
module rcad_top_tb;
  import rcad_pkg::*;
  typedef struct { logic [DATA_W-1:0] e; int t; } rcad_exp_type;
  logic clk = 1'b0, nrst = 1'b0, base_clock = 1'b0;
  rcad_avm_req_type avs_req = '0;
  logic [DATA_W-1:0] avs_readdata, d;
  logic avs_waitrequest, oscillator_clock, osc_enable, conv_interrupt_request;
  logic [OSC_MODE_W-1:0] oscillation_mode_field;
  rcad_exp_type exp_q[$];
  int fail_count = 0, n_tests = 0, bcnt = 0, k;
  // ****************
  // Clocks and instances
  // ****************
  always #5 clk = ~clk;
  // Base clock period is 12 clk, slow enough for the edge detectors
  always @(posedge clk)
  begin
    bcnt <= (bcnt == 5) ? 0 : bcnt + 1;
    if (bcnt == 5) base_clock <= ~base_clock;
  end
  rcad_top rcad_top_inst (.clk(clk), .nrst(nrst), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .base_clock(base_clock), .oscillator_clock(oscillator_clock), .osc_enable(osc_enable),
    .oscillation_mode_field(oscillation_mode_field),
    .conv_interrupt_request(conv_interrupt_request));
  rcad_rc_net #(.HALF(3)) rcad_rc_net_inst (.clk(clk), .nrst(nrst),
    .osc_enable(osc_enable), .oscillator_clock(oscillator_clock));
  // ****************
  // Checks and bus tasks
  // ****************
  task chk(input logic [DATA_W-1:0] g, e, input int t);
    n_tests++;
    if (((g - e + t) <= 2 * t) !== 1'b1)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  always @(posedge clk)
    if (avs_req.read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
    begin
      rcad_exp_type x;
      x = exp_q.pop_front();
      chk(avs_readdata, x.e, x.t);
    end
  task xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    int i;
    @(posedge clk);
    avs_req <= '{read: !w, write: w, address: a, writedata: v, byteenable: 4'hf};
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 8)
    begin
      fail_count++;
      finish_test();
    end
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input int t);
    exp_q.push_back('{e, t});
    xfer(1'b0, a, DATA_ZERO);
  endtask
  task wait_irq(input int n, input logic want);
    int i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < n && !seen; i++)
    begin
      @(posedge clk);
      seen = (conv_interrupt_request === 1'b1);
    end
    chk({31'h0, seen}, {31'h0, want}, 0);
  endtask
  task preset(input logic [CNT_W-1:0] pa, pb, input logic [MODE_W-1:0] m);
    xfer(1'b1, OFFS_A_LOW, {16'h0, pa[15:0]});
    xfer(1'b1, OFFS_A_HIGH, {24'h0, pa[23:16]});
    xfer(1'b1, OFFS_B_LOW, {16'h0, pb[15:0]});
    xfer(1'b1, OFFS_B_HIGH, {24'h0, pb[23:16]});
    xfer(1'b1, OFFS_MODE, {27'h0, m});
    xfer(1'b1, OFFS_CTRL, 32'h1);
    rd(OFFS_CTRL, 32'h1, 0);
  endtask
  // Counts drift by one with the phase of the clocks against the gate
  task conv(input logic [CNT_W-1:0] pa, pb, ea, eb, input logic [MODE_W-1:0] m, input int t);
    preset(pa, pb, m);
    wait_irq(3000, 1'b1);
    rd(OFFS_A_LOW, {16'h0, ea[15:0]}, m[4] ? t : 0);
    rd(OFFS_B_LOW, {16'h0, eb[15:0]}, m[4] ? 0 : t);
    rd(OFFS_A_HIGH, DATA_ZERO, 0);
    rd(OFFS_CTRL, DATA_ZERO, 0);
    chk(osc_enable, 1'b0, 0);
  endtask
  task finish_test;
    $display("Counts: %0d compared, %0d failed", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    void'($urandom(32'h8b3b7873));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (k = 0; k < 8; k++) rd(5'(4 * k), DATA_ZERO, 0);
    $display("reset values done");
    for (k = 0; k < 4; k++)
    begin
      d = $urandom;
      xfer(1'b1, OFFS_A_LOW + 5'(4 * k), d);
      rd(OFFS_A_LOW + 5'(4 * k), d & ((k % 2) ? 32'hff : 32'hffff), 0);
    end
    d = $urandom;
    xfer(1'b1, OFFS_MODE, d);
    rd(OFFS_MODE, d & 32'h1f, 0);
    chk(oscillation_mode_field, d[3:0], 0);
    xfer(1'b1, 5'h1c, $urandom);
    rd(5'h1c, DATA_ZERO, 0);
    $display("register access done");
    // Gate of 4 base clocks opens half a base period before its first edge
    conv(24'hfffffc, 24'h0, 24'h0, 24'd7, 5'h01, 1);
    $display("counter A reference done");
    // Second step of one measurement; software takes the ratio of the two
    conv(24'h0, 24'hfffff8, 24'd4, 24'h0, 5'h12, 1);
    $display("counter B reference done");
    preset(24'h0, 24'hfffff8, 5'h18);
    wait_irq(300, 1'b0);
    chk(osc_enable, 1'b0, 0);
    xfer(1'b1, OFFS_CTRL, DATA_ZERO);
    rd(OFFS_CTRL, DATA_ZERO, 0);
    $display("barred mode done");
    finish_test();
  end
endmodule // rcad_top_tb
